// ### rtl/ulh_pkg.sv
// constants, types and helpers for the lin header controller

package ulh_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  ULH_OFS_PORT_PERSONALITY_SELECT = 8'h30;
  localparam logic [7:0]  ULH_OFS_LIN_CTL = 8'h34;
  localparam logic [7:0]  ULH_OFS_STATUS  = 8'h38;
  localparam logic [31:0] ULH_PORT_PERSONALITY_SELECT_RST = 32'h0000_0000;
  localparam logic [31:0] ULH_LIN_CTL_RST = 32'h000C_0000;
  localparam logic [31:0] ULH_PORT_PERSONALITY_SELECT_MSK = 32'h0000_0003;
  localparam logic [31:0] ULH_LIN_CTL_MSK = 32'hFFFF_1F1F;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ULH_PID_LSB   = 24;
  localparam int ULH_PAR_LSB   = 30;
  localparam int ULH_HSEL_LSB  = 22;
  localparam int ULH_BSLEN_LSB = 20;
  localparam int ULH_BKFL_LSB  = 16;
  localparam int ULH_BIT_IDPEN = 9;
  localparam int ULH_BIT_SHD   = 8;
  localparam int ULH_BIT_MUTE  = 4;
  localparam int ULH_ST_BUSY   = 0;
  localparam int ULH_ST_MUTE   = 1;
  localparam int ULH_ST_PERR   = 2;

  // ****************************************************************
  // codes and framing
  // ****************************************************************
  typedef enum logic [1:0] {
    ULH_PS_UART  = 2'b00,
    ULH_PS_LIN   = 2'b01,
    ULH_PS_IRDA  = 2'b10,
    ULH_PS_RS485 = 2'b11
  } ulh_pers_t;

  typedef enum logic [1:0] {
    ULH_HS_BRK  = 2'b00,
    ULH_HS_SYNC = 2'b01,
    ULH_HS_FULL = 2'b10,
    ULH_HS_RSVD = 2'b11
  } ulh_hsel_t;

  localparam logic [7:0] ULH_SYNC_BYTE   = 8'h55;
  localparam logic [3:0] ULH_FRAME_LAST  = 4'h9;
  localparam int         ULH_LIN_PORTS   = 3;
  localparam int         ULH_RS485_PORTS = 2;

  // parity pair {p1, p0} for a six-bit identifier
  function automatic logic [1:0] ulh_pid_parity(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0};
  endfunction : ulh_pid_parity

endpackage : ulh_pkg

// ### rtl/ulh_bit_timer.sv
// bit-time tick generator for the header transmitter
`timescale 1ns/1ns
`default_nettype none

module ulh_bit_timer #(
  parameter int unsigned DIV = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output var  logic tick
);

  localparam logic [15:0] LAST = 16'(DIV - 1);

  logic [15:0] cnt_q;

  // ****************************************************************
  // divider, restarted whenever the transmitter idles
  // ****************************************************************
  // restart keeps the first bit of a header a full bit time long
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q == LAST) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // one-cycle pulse at the end of each bit time
  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (cnt_q == LAST);
    end
  end

endmodule : ulh_bit_timer

`default_nettype wire

// ### rtl/ulh_lin_header.sv
// function select and lin header controller of one serial port
`timescale 1ns/1ns
`default_nettype none

module ulh_lin_header
  import ulh_pkg::*;
#(
  parameter int unsigned PORT_INDEX = 0,
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic        rx_break_seen,
  input  wire logic        rx_sync_seen,
  input  wire logic        rx_id_seen,
  input  wire logic [7:0]  rx_id_byte,
  output var  logic        lin_tx,
  output var  logic        lin_tx_busy,
  output var  logic [1:0]  port_personality,
  output var  logic        mute_active,
  output var  logic        id_parity_err
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  typedef enum logic [2:0] {
    ULH_ST_IDLE  = 3'b000,
    ULH_ST_BREAK = 3'b001,
    ULH_ST_DELIM = 3'b010,
    ULH_ST_SYNC  = 3'b011,
    ULH_ST_PID   = 3'b100
  } ulh_state_t;

  localparam bit LIN_OK   = PORT_INDEX < ULH_LIN_PORTS;
  localparam bit RS485_OK = PORT_INDEX < ULH_RS485_PORTS;

  ulh_state_t  state_q;
  logic [31:0] fun_q;
  logic [31:0] lin_q;
  logic [3:0]  cnt_q;
  logic [9:0]  shift_q;
  logic        done_q;
  logic        bit_tick;

  logic        wr_fun;
  logic        wr_lin;
  logic        wr_stat;
  logic        lin_mode;
  logic        shd;
  logic        idpen;
  logic        mute_en;
  ulh_hsel_t   hsel;
  logic [1:0]  bslen;
  logic [3:0]  bkfl;
  logic [7:0]  pid;
  logic [31:0] lin_wr_val;
  logic [1:0]  fun_wr_val;
  logic        start_hdr;
  logic        drop_hdr;
  logic        mute_end;
  logic        perr_set;
  logic        hdr_req;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one step down of a bit or phase counter
  function automatic logic [3:0] count_down(input logic [3:0] v);
    return v - 4'h1;
  endfunction : count_down

  // header ends with the phase now closing; only the completion pulse
  // uses it, the sequencer repeats the same conditions in its case branches
  function automatic logic last_phase(input ulh_state_t st,
                                      input ulh_hsel_t  hs);
    return (st == ULH_ST_DELIM && hs == ULH_HS_BRK) ||
           (st == ULH_ST_SYNC && hs != ULH_HS_FULL) ||
           (st == ULH_ST_PID);
  endfunction : last_phase

  // ****************************************************************
  // register decode
  // ****************************************************************
  assign wr_fun  = reg_wr && (reg_addr == ULH_OFS_PORT_PERSONALITY_SELECT);
  assign wr_lin  = reg_wr && (reg_addr == ULH_OFS_LIN_CTL);
  assign wr_stat = reg_wr && (reg_addr == ULH_OFS_STATUS);

  // control fields as seen by the header logic
  assign shd     = lin_q[ULH_BIT_SHD];
  assign idpen   = lin_q[ULH_BIT_IDPEN];
  assign mute_en = lin_q[ULH_BIT_MUTE];
  assign hsel    = ulh_hsel_t'(lin_q[ULH_HSEL_LSB +: 2]);
  assign bslen   = lin_q[ULH_BSLEN_LSB +: 2];
  assign bkfl    = lin_q[ULH_BKFL_LSB +: 4];
  assign pid     = lin_q[ULH_PID_LSB +: 8];
  assign lin_mode = (fun_q[1:0] == ULH_PS_LIN);

  // ****************************************************************
  // function selector
  // ****************************************************************
  // codes a port cannot support fall back to plain uart
  always_comb begin
    fun_wr_val = reg_wdata[1:0];
    if (fun_wr_val == ULH_PS_LIN && !LIN_OK) begin
      fun_wr_val = ULH_PS_UART;
    end
    if (fun_wr_val == ULH_PS_RS485 && !RS485_OK) begin
      fun_wr_val = ULH_PS_UART;
    end
  end

  // selector storage, reserved bits forced low
  always_ff @(posedge clk) begin
    if (rst) begin
      fun_q <= ULH_PORT_PERSONALITY_SELECT_RST;
    end else if (wr_fun) begin
      fun_q <= {30'h0000_0000, fun_wr_val} & ULH_PORT_PERSONALITY_SELECT_MSK;
    end
  end

  // personality seen by the rest of the port
  always_ff @(posedge clk) begin
    if (rst) begin
      port_personality <= ULH_PS_UART;
    end else begin
      port_personality <= fun_q[1:0];
    end
  end

  // ****************************************************************
  // lin control register
  // ****************************************************************
  // parity is folded in at write time so readback shows the real pid
  always_comb begin
    lin_wr_val = reg_wdata & ULH_LIN_CTL_MSK;
    if (reg_wdata[ULH_BIT_IDPEN]) begin
      lin_wr_val[ULH_PAR_LSB +: 2] =
        ulh_pid_parity(reg_wdata[ULH_PID_LSB +: 6]);
    end
  end

  // software write wins over the hardware clear of the send request
  always_ff @(posedge clk) begin
    if (rst) begin
      lin_q <= ULH_LIN_CTL_RST;
    end else if (wr_lin) begin
      lin_q <= lin_wr_val;
    end else if (done_q) begin
      lin_q[ULH_BIT_SHD] <= 1'b0;
    end
  end

  // ****************************************************************
  // header transmitter
  // ****************************************************************
  // pending request seen by an idle sequencer in lin personality
  assign hdr_req   = (state_q == ULH_ST_IDLE) && shd && lin_mode && !done_q;
  // a reserved header code is dropped rather than left pending forever
  assign start_hdr = hdr_req && (hsel != ULH_HS_RSVD);
  assign drop_hdr  = hdr_req && (hsel == ULH_HS_RSVD);

  ulh_bit_timer #(
    .DIV (BIT_CYCLES)
  ) u_bit_timer (
    .clk  (clk),
    .rst  (rst),
    .run  (state_q != ULH_ST_IDLE),
    .tick (bit_tick)
  );

  // sequencer: break, delimiter, then framed bytes lsb first
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ULH_ST_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 10'h3FF;
      lin_tx  <= 1'b1;
    end else begin
      unique case (state_q)
        // idle: line high until a request is taken
        ULH_ST_IDLE: begin
          if (start_hdr) begin
            state_q <= ULH_ST_BREAK;
            cnt_q   <= bkfl;
            lin_tx  <= 1'b0;
          end
        end
        // break: line low for count plus one bit times
        ULH_ST_BREAK: begin
          if (bit_tick) begin
            if (cnt_q == 4'h0) begin
              state_q <= ULH_ST_DELIM;
              cnt_q   <= {2'b00, bslen};
              lin_tx  <= 1'b1;
            end else begin
              cnt_q <= count_down(cnt_q);
            end
          end
        end
        // delimiter: line high for length code plus one bit times
        ULH_ST_DELIM: begin
          if (bit_tick) begin
            if (cnt_q != 4'h0) begin
              cnt_q <= count_down(cnt_q);
            end else if (hsel == ULH_HS_BRK) begin
              state_q <= ULH_ST_IDLE;
            end else begin
              state_q <= ULH_ST_SYNC;
              cnt_q   <= ULH_FRAME_LAST;
              shift_q <= {1'b1, ULH_SYNC_BYTE, 1'b0};
              lin_tx  <= 1'b0;
            end
          end
        end
        // framed bytes: start bit, eight data bits, stop bit
        ULH_ST_SYNC,
        ULH_ST_PID: begin
          if (bit_tick) begin
            if (cnt_q != 4'h0) begin
              cnt_q   <= count_down(cnt_q);
              shift_q <= {1'b1, shift_q[9:1]};
              lin_tx  <= shift_q[1];
            end else if (state_q == ULH_ST_SYNC
                         && hsel == ULH_HS_FULL) begin
              state_q <= ULH_ST_PID;
              cnt_q   <= ULH_FRAME_LAST;
              shift_q <= {1'b1, pid, 1'b0};
              lin_tx  <= 1'b0;
            end else begin
              state_q <= ULH_ST_IDLE;
              lin_tx  <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= ULH_ST_IDLE;
          lin_tx  <= 1'b1;
        end
      endcase
    end
  end

  // one-cycle completion pulse that clears the send request
  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= drop_hdr || (bit_tick && cnt_q == 4'h0
                && last_phase(state_q, hsel));
    end
  end

  // busy flag follows the sequencer, visible one cycle after start
  always_ff @(posedge clk) begin
    if (rst) begin
      lin_tx_busy <= 1'b0;
    end else begin
      lin_tx_busy <= (state_q != ULH_ST_IDLE);
    end
  end

  // ****************************************************************
  // slave side: mute exit and identifier parity check
  // ****************************************************************
  // the header select names which received portion ends mute
  always_comb begin
    unique case (hsel)
      ULH_HS_BRK:  mute_end = rx_break_seen;
      ULH_HS_SYNC: mute_end = rx_sync_seen;
      ULH_HS_FULL: mute_end = rx_id_seen;
      ULH_HS_RSVD: mute_end = 1'b0;
    endcase
  end

  // entering mute is a software write, so it wins over a same-cycle exit
  always_ff @(posedge clk) begin
    if (rst) begin
      mute_active <= 1'b0;
    end else if (wr_lin) begin
      mute_active <= reg_wdata[ULH_BIT_MUTE] && lin_mode;
    end else if (!mute_en || !lin_mode) begin
      mute_active <= 1'b0;
    end else if (mute_end) begin
      mute_active <= 1'b0;
    end
  end

  assign perr_set = rx_id_seen && idpen && lin_mode &&
    (rx_id_byte[7:6] != ulh_pid_parity(rx_id_byte[5:0]));

  // sticky parity error, cleared by writing one; a new error wins
  always_ff @(posedge clk) begin
    if (rst) begin
      id_parity_err <= 1'b0;
    end else if (perr_set) begin
      id_parity_err <= 1'b1;
    end else if (wr_stat && reg_wdata[ULH_ST_PERR]) begin
      id_parity_err <= 1'b0;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // status word rebuilt every cycle from the live flags
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ULH_ST_BUSY] = lin_tx_busy;
    status_word[ULH_ST_MUTE] = mute_active;
    status_word[ULH_ST_PERR] = id_parity_err;
  end

  // word picked by the read address; unmapped offsets read zero
  always_comb begin
    unique case (reg_addr)
      ULH_OFS_PORT_PERSONALITY_SELECT: rd_word = fun_q;
      ULH_OFS_LIN_CTL: rd_word = lin_q;
      ULH_OFS_STATUS:  rd_word = status_word;
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_word;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : ulh_lin_header

`default_nettype wire

// ### test/ulh_lin_header_properties.sv
// port assertions of the lin header controller
`timescale 1ns/1ns
`default_nettype none

module ulh_lin_header_properties
  import ulh_pkg::*;
#(
  parameter int unsigned PORT_INDEX = 0,
  parameter int unsigned BIT_CYCLES = 16
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        rx_id_seen,
  input wire logic [7:0]  rx_id_byte,
  input wire logic        lin_tx,
  input wire logic        lin_tx_busy,
  input wire logic [1:0]  port_personality,
  input wire logic        mute_active,
  input wire logic        id_parity_err
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  localparam int HDR_MAX = 1000; // bound above the longest header at default bit time (640 cycles)
  logic [15:0] low_q;
  logic        id_ok;

  // length of the current low run on the line
  always_ff @(posedge clk) begin
    if (rst || lin_tx) low_q <= 16'h0;
    else low_q <= low_q + 16'h1;
  end

  // received identifier carries matching parity
  assign id_ok = rx_id_byte[6] == ^{rx_id_byte[4], rx_id_byte[2:0]}
              && rx_id_byte[7] == ~^{rx_id_byte[5:3], rx_id_byte[1]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // properties
  // ****************************************************************
  sequence s_hdr_start;
    $fell(lin_tx) && !lin_tx_busy;
  endsequence
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  property p_sel_rd;
    reg_rd && reg_addr == ULH_OFS_PORT_PERSONALITY_SELECT
      |=> reg_rdata == {30'h0, port_personality};
  endproperty
  property p_pers_hold;
    !($past(reg_wr, 2) && $past(reg_addr, 2) == ULH_OFS_PORT_PERSONALITY_SELECT)
      |-> $stable(port_personality);
  endproperty
  property p_lin_ports;
    !(port_personality == ULH_PS_LIN && PORT_INDEX >= ULH_LIN_PORTS) &&
    !(port_personality == ULH_PS_RS485 && PORT_INDEX >= ULH_RS485_PORTS);
  endproperty
  property p_hdr_busy; s_hdr_start |=> lin_tx_busy; endproperty
  property p_hdr_end;
    $rose(lin_tx_busy) |-> ##[1:HDR_MAX] !lin_tx_busy;
  endproperty
  property p_bit_len; $rose(lin_tx) |-> low_q >= BIT_CYCLES; endproperty
  property p_mute_lin;
    port_personality != ULH_PS_LIN |-> !mute_active;
  endproperty
  property p_perr_cause;
    $rose(id_parity_err) |-> $past(rx_id_seen) && !$past(id_ok);
  endproperty
  property p_perr_good;
    rx_id_seen && id_ok && !id_parity_err |=> !id_parity_err;
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  a_sel_rd: assert property (p_sel_rd)
    else $error("selector read differs from personality");
  a_pers_hold: assert property (p_pers_hold)
    else $error("personality moved without a write");
  a_lin_ports: assert property (p_lin_ports)
    else $error("lin personality on a port without it");
  a_hdr_busy: assert property (p_hdr_busy)
    else $error("header start without busy");
  a_hdr_end: assert property (p_hdr_end)
    else $error("header never finished");
  a_bit_len: assert property (p_bit_len)
    else $error("low run shorter than a bit");
  a_mute_lin: assert property (p_mute_lin)
    else $error("mute outside lin personality");
  a_perr_cause: assert property (p_perr_cause)
    else $error("parity error without a bad identifier");
  a_perr_good: assert property (p_perr_good)
    else $error("parity error on a good identifier");
endmodule : ulh_lin_header_properties
`default_nettype wire

// ### test/ulh_lin_node.sv
// behavioural lin node on the far side of the serial line
`timescale 1ns/1ns
`default_nettype none

module ulh_lin_node #(
  parameter int BC = 4
) (
  input  wire logic       clk,
  input  wire logic       lin_tx,
  input  wire logic       hdr_go,
  input  wire logic [7:0] hdr_id,
  output logic            rx_break_seen = 1'b0,
  output logic            rx_sync_seen = 1'b0,
  output logic            rx_id_seen = 1'b0,
  output logic [7:0]      rx_id_byte = 8'h0,
  output logic            busy = 1'b0,
  output int              brks = 0,
  output int              brk_bits,
  output int              delim_bits,
  output int              nbytes,
  output logic [7:0]      by0,
  output logic [7:0]      by1
);
  // ****************************************************************
  // remote master and listener
  // ****************************************************************
  logic [3:0] gc_q = 4'h0;

  // fixed pulse schedule after a go request
  always @(posedge clk) begin
    gc_q <= hdr_go ? 4'h1 : (gc_q != 4'h0 && gc_q < 4'hC) ? gc_q + 4'h1 : 4'h0;
    rx_break_seen <= (gc_q == 4'h1);
    rx_sync_seen <= (gc_q == 4'h5);
    rx_id_seen <= (gc_q == 4'h9);
    // byte only valid with its pulse, so toggle it otherwise
    rx_id_byte <= (gc_q == 4'h9) ? hdr_id : ~rx_id_byte;
  end

  // measure break and delimiter, sample framed bytes at mid-bit
  initial begin
    int n;
    logic [7:0] b;
    forever begin
      @(negedge lin_tx);
      busy = 1'b1;
      nbytes = 0;
      n = 0;
      while (!lin_tx) begin
        @(posedge clk);
        n++;
      end
      brk_bits = n / BC;
      brks++;
      do begin
        n = 0;
        while (lin_tx && n < 8 * BC) begin
          @(posedge clk);
          n++;
        end
        if (nbytes == 0) delim_bits = (n + BC / 2) / BC;
        if (!lin_tx) begin
          repeat (BC / 2) @(posedge clk);
          for (int i = 0; i < 8; i++) begin
            repeat (BC) @(posedge clk);
            b[i] = lin_tx;
          end
          repeat (BC) @(posedge clk);
          if (nbytes == 0) by0 = b;
          else by1 = b;
          nbytes++;
        end
      end while (n < 8 * BC);
      busy = 1'b0;
    end
  end
endmodule : ulh_lin_node
`default_nettype wire

// ### test/ulh_lin_header_test.sv
// self-checking testbench of the lin header controller
`timescale 1ns/1ns
`default_nettype none

module ulh_lin_header_test import ulh_pkg::*;;
  // ****************************************************************
  // signals and helpers
  // ****************************************************************
  localparam int BC = 4; // short bit time keeps the run brief
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, rv, d, e;
  logic        rx_break_seen, rx_sync_seen, rx_id_seen;
  logic [7:0]  rx_id_byte, by0, by1;
  logic        lin_tx, lin_tx_busy, mute_active, id_parity_err, p_busy;
  logic [1:0]  port_personality, pers_b;
  logic        hdr_go = 1'b0;
  logic [7:0]  hdr_id = 8'h0;
  logic [15:0] lf = 16'h0014;
  int          brks, brk_bits, delim_bits, nbytes, n0;
  int          error_cnt = 0;
  int          compares = 0;

  initial forever #5 clk = ~clk;

  ulh_lin_header #(.BIT_CYCLES(BC)) dut_u (.clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_break_seen,
    .rx_sync_seen, .rx_id_seen, .rx_id_byte, .lin_tx, .lin_tx_busy,
    .port_personality, .mute_active, .id_parity_err);

  // third port: lin allowed, rs485 not
  ulh_lin_header #(.PORT_INDEX(2), .BIT_CYCLES(BC)) dut_b_u (.clk, .rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(), .rx_break_seen,
    .rx_sync_seen, .rx_id_seen, .rx_id_byte, .lin_tx(), .lin_tx_busy(),
    .port_personality(pers_b), .mute_active(), .id_parity_err());

  ulh_lin_node #(.BC(BC)) node_u (.clk, .lin_tx, .hdr_go, .hdr_id,
    .rx_break_seen, .rx_sync_seen, .rx_id_seen, .rx_id_byte,
    .busy(p_busy), .brks, .brk_bits, .delim_bits, .nbytes, .by0, .by1);

  function automatic logic [1:0] par(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4]};
  endfunction : par

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx

  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic wrap_up;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // polls until send request drops and the listener is idle
  task automatic wait_hdr;
    for (int i = 0; i < 400; i++) begin
      rd(ULH_OFS_LIN_CTL, rv);
      if (rv[ULH_BIT_SHD] === 1'b0 && !p_busy) return;
    end
    error_cnt++;
    wrap_up();
  endtask : wait_hdr

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ULH_OFS_PORT_PERSONALITY_SELECT, rv);
    chk("sel_rst", rv, ULH_PORT_PERSONALITY_SELECT_RST);
    rd(ULH_OFS_LIN_CTL, rv);
    chk("ctl_rst", rv, ULH_LIN_CTL_RST);
    rd(8'h3C, rv);
    chk("unmapped", rv, 32'h0);
    // every selector code, junk in the reserved bits
    for (int s = 0; s < 4; s++) begin
      lf = nx(lf);
      wr(ULH_OFS_PORT_PERSONALITY_SELECT, {lf, lf[13:0], s[1:0]});
      rd(ULH_OFS_PORT_PERSONALITY_SELECT, rv);
      chk("sel", rv, {30'h0, s[1:0]});
      chk("pers", port_personality, s[1:0]);
      chk("pers_b", pers_b, (s == 3) ? 2'b00 : s[1:0]);
    end
    // control writes with and without hardware parity
    for (int i = 0; i < 6; i++) begin
      lf = nx(lf);
      d = (i == 0) ? 32'hFFFF_FEFF : {lf, nx(lf)} & 32'hFFFF_FEFF;
      wr(ULH_OFS_LIN_CTL, d);
      e = d & ULH_LIN_CTL_MSK;
      if (d[ULH_BIT_IDPEN]) e[31:30] = par(d[29:24]);
      rd(ULH_OFS_LIN_CTL, rv);
      chk("ctl", rv, e);
    end
    // master headers for every select code, reserved one last
    wr(ULH_OFS_PORT_PERSONALITY_SELECT, 32'h1);
    for (int h = 0; h < 4; h++) begin
      lf = nx(lf);
      n0 = brks;
      wr(ULH_OFS_LIN_CTL, {lf[15:8], h[1:0], lf[5:0], 8'h3, 8'h0});
      wait_hdr();
      chk("brks", brks - n0, (h < 3) ? 1 : 0);
      if (h < 3) begin
        chk("brk", brk_bits, lf[3:0] + 1);
        chk("nbytes", nbytes, h);
      end
      if (h == 1 || h == 2) begin
        chk("delim", delim_bits, lf[5:4] + 1);
        chk("sync", by0, ULH_SYNC_BYTE);
      end
      if (h == 2) chk("pid", by1, {par(lf[13:8]), lf[13:8]});
    end
    // slave mute release and parity check, bad parity when h is 0
    for (int h = 0; h < 3; h++) begin
      lf = nx(lf);
      wr(ULH_OFS_LIN_CTL, {8'h0, h[1:0], 6'h0C, 8'h2, 8'h10});
      #1 chk("mute_on", mute_active, 1'b1);
      @(posedge clk);
      hdr_go <= 1'b1;
      hdr_id <= {par(lf[5:0]) ^ {1'b0, h == 0}, lf[5:0]};
      @(posedge clk);
      hdr_go <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("mute_brk", mute_active, h != 0);
      repeat (4) @(posedge clk);
      #1 chk("mute_sync", mute_active, h == 2);
      repeat (4) @(posedge clk);
      #1 chk("mute_id", mute_active, 1'b0);
      chk("perr", id_parity_err, h == 0);
      wr(ULH_OFS_STATUS, 32'h4);
      #1 chk("perr_clr", id_parity_err, 1'b0);
    end
    wrap_up();
  end
endmodule : ulh_lin_header_test

bind ulh_lin_header ulh_lin_header_properties #(
  .PORT_INDEX(PORT_INDEX), .BIT_CYCLES(BIT_CYCLES)) prop_u (.clk(clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_id_seen(rx_id_seen),
  .rx_id_byte(rx_id_byte), .lin_tx(lin_tx), .lin_tx_busy(lin_tx_busy),
  .port_personality(port_personality), .mute_active(mute_active),
  .id_parity_err(id_parity_err));
`default_nettype wire
